// ---- design/pcu_channel.sv ----
// one modulation channel: counter, buffered update, enable status, bus slave
`timescale 1ns/10ps
`include "pcu_cfg.svh"
module pcu_channel (
    input  wire logic               clk_sys,   // system clock, 100 MHz
    input  wire logic               reset_n,   // async reset, active low
    input  wire pcu_pkg::pcu_addr_t bus_addr,  // register byte address
    input  wire pcu_pkg::pcu_word_t bus_wdata, // write data
    input  wire logic               bus_wr,    // write strobe
    input  wire logic               bus_rd,    // read strobe
    output pcu_pkg::pcu_word_t      bus_rdata, // read data, cycle after strobe
    output logic                    pwm_out,   // modulated line level
    output logic                    pwm_oe,    // high while the line is driven
    output logic                    irq        // level interrupt
);
    import pcu_pkg::*;
    // ==========================================================
    // decoded strobes
    logic wr_enable;                 // enable command
    logic wr_disable;                // disable command
    logic wr_mode;                   // mode write
    logic wr_duty;                   // direct duty write
    logic wr_period;                 // direct period write
    logic wr_update;                 // update register write

    assign wr_enable  = bus_wr && (bus_addr == `PCU_OFS_ENABLE) && bus_wdata[`PCU_CMD_BIT];
    assign wr_disable = bus_wr && (bus_addr == `PCU_OFS_DISABLE) && bus_wdata[`PCU_CMD_BIT];
    assign wr_mode    = bus_wr && (bus_addr == `PCU_OFS_MODE);
    assign wr_duty    = bus_wr && (bus_addr == `PCU_OFS_DUTY);
    assign wr_period  = bus_wr && (bus_addr == `PCU_OFS_PERIOD);
    assign wr_update  = bus_wr && (bus_addr == `PCU_OFS_UPDATE);

    // ==========================================================
    // state
    pcu_state_e  state;              // idle or running
    logic [7:0]  mode;               // polarity, alignment, target, prescaler
    pcu_cnt_t    duty;               // active duty value
    pcu_cnt_t    period;             // active period value
    pcu_cnt_t    cnt;                // channel counter
    logic        cnt_down;           // center mode direction
    logic        en_flag;            // enabled status bit
    logic        tick_seen;          // one selected clock period done since enable
    pcu_cnt_t    upd_val;            // buffered update value
    logic        upd_tgt_period;     // buffered update goes to period
    logic        upd_pending;        // buffered update waiting
    logic        running;            // counter active
    logic        tick;               // selected clock tick
    logic        period_end;         // last tick of a period
    logic        upd_now;            // update write taking effect at once
    logic        upd_commit;         // buffered update lands this cycle
    logic        calg;               // center aligned mode
    pcu_word_t   next_rdata;         // read mux

    assign running = (state == PCU_RUN);
    assign calg    = mode[`PCU_MODE_CALG];

    // ==========================================================
    // selected clock
    pcu_clkdiv #(.DIVW(`PCU_DIVW)) u_div (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .run     (running),
        .pre_sel (mode[`PCU_MODE_PRE_HI:`PCU_MODE_PRE_LO]),
        .tick    (tick)
    );

    // period ends at the top in left mode, back at zero in center mode
    assign period_end = tick && (calg ? (cnt_down && cnt == `PCU_CNT_ZERO)
                                      : (cnt == period));

    // ==========================================================
    // run state machine
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= PCU_IDLE;
        end else begin
            case (state)
                PCU_IDLE: begin
                    if (wr_enable) begin
                        state <= PCU_RUN;
                    end
                end
                PCU_RUN: begin
                    if (wr_disable) begin
                        state <= PCU_IDLE;           // output stops at once
                    end
                end
                default: begin
                    state <= PCU_IDLE;
                end
            endcase
        end
    end

    // enabled flag: a disable too soon after enable leaves it set
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            en_flag   <= 1'b0;
            tick_seen <= 1'b0;
        end else if (wr_enable) begin
            en_flag   <= 1'b1;
            tick_seen <= 1'b0;
        end else if (wr_disable) begin
            en_flag   <= en_flag && !tick_seen;
        end else if (running && tick) begin
            tick_seen <= 1'b1;
        end
    end

    // mode register, written and used in either state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode <= `PCU_MODE_RST;
        end else if (wr_mode) begin
            mode <= bus_wdata[7:0];
        end
    end

    // ==========================================================
    // channel counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt      <= `PCU_CNT_ZERO;
            cnt_down <= 1'b0;
        end else if (!running || wr_enable) begin
            cnt      <= `PCU_CNT_ZERO;           // first period starts at 0
            cnt_down <= 1'b0;
        end else if (tick) begin
            if (!calg) begin
                // later periods restart at 1
                cnt <= (cnt == period) ? `PCU_CNT_ONE : cnt + `PCU_CNT_ONE;
            end else if (!cnt_down && cnt == period) begin
                cnt_down <= 1'b1;
                cnt      <= cnt - `PCU_CNT_ONE;
            end else if (cnt_down && cnt == `PCU_CNT_ZERO) begin
                cnt_down <= 1'b0;
                cnt      <= `PCU_CNT_ONE;
            end else begin
                cnt <= cnt_down ? cnt - `PCU_CNT_ONE : cnt + `PCU_CNT_ONE;
            end
        end
    end

    // ==========================================================
    // update path
    // counter at 0 or 1 lets the write through at once; software is
    // expected to check the counter first to avoid this
    assign upd_now    = wr_update && (cnt == `PCU_CNT_ZERO || cnt == `PCU_CNT_ONE);
    assign upd_commit = upd_pending && period_end;

    // buffered value and its target
    // a buffered write in the cycle of a commit lands the older value and
    // leaves the new one waiting for the following period end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            upd_val        <= `PCU_CNT_ZERO;
            upd_tgt_period <= 1'b0;
            upd_pending    <= 1'b0;
        end else if (wr_update && !upd_now) begin
            upd_val        <= bus_wdata[`PCU_CW-1:0];
            upd_tgt_period <= mode[`PCU_MODE_CPD];
            upd_pending    <= 1'b1;              // wait for period end
        end else if (upd_commit || upd_now) begin
            upd_pending    <= 1'b0;
        end
    end

    // duty register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            duty <= `PCU_DUTY_RST;
        end else if (wr_duty && !running) begin
            duty <= bus_wdata[`PCU_CW-1:0];
        end else if (upd_now && !mode[`PCU_MODE_CPD]) begin
            duty <= bus_wdata[`PCU_CW-1:0];
        end else if (upd_commit && !upd_tgt_period) begin
            duty <= upd_val;
        end
    end

    // period register; a zero period blocks the buffered update
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            period <= `PCU_PERIOD_RST;
        end else if (wr_period && !running) begin
            period <= bus_wdata[`PCU_CW-1:0];
        end else if (upd_now && mode[`PCU_MODE_CPD]) begin
            period <= bus_wdata[`PCU_CW-1:0];
        end else if (upd_commit && upd_tgt_period && period != `PCU_CNT_ZERO) begin
            period <= upd_val;
        end
    end

    // ==========================================================
    // output line, registered; idle level is the inverse polarity
    // the disable strobe gates the line in its own cycle, so a stopped
    // channel never shows one more active level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pwm_out <= 1'b0;
            pwm_oe  <= 1'b0;
        end else begin
            pwm_oe  <= running && !wr_disable;
            pwm_out <= (running && !wr_disable && cnt < duty) ^ !mode[`PCU_MODE_CPOL];
        end
    end

    // ==========================================================
    // interrupt unit
    pcu_evt_if ev ();

    assign ev.event_pulse = {upd_commit || upd_now, period_end && running};
    assign ev.clr_wr      = bus_wr && (bus_addr == `PCU_OFS_ISR);
    assign ev.mask_wr     = bus_wr && (bus_addr == `PCU_OFS_IMR);
    assign ev.wr_bits     = bus_wdata[`PCU_EVW-1:0];

    pcu_irq u_irq (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ev      (ev.sink),
        .irq     (irq)
    );

    // ==========================================================
    // read mux, unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        if (bus_addr == `PCU_OFS_STATUS) begin
            next_rdata[0] = en_flag;
        end else if (bus_addr == `PCU_OFS_MODE) begin
            next_rdata[7:0] = mode;
        end else if (bus_addr == `PCU_OFS_DUTY) begin
            next_rdata[`PCU_CW-1:0] = duty;
        end else if (bus_addr == `PCU_OFS_PERIOD) begin
            next_rdata[`PCU_CW-1:0] = period;
        end else if (bus_addr == `PCU_OFS_UPDATE) begin
            next_rdata[`PCU_CW-1:0] = upd_val;
        end else if (bus_addr == `PCU_OFS_COUNT) begin
            next_rdata[`PCU_CW-1:0] = cnt;
        end else if (bus_addr == `PCU_OFS_ISR) begin
            next_rdata[`PCU_EVW-1:0] = ev.status;
        end else if (bus_addr == `PCU_OFS_IMR) begin
            next_rdata[`PCU_EVW-1:0] = ev.mask;
        end
    end

    // read data stand one cycle only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata <= '0;
        end else begin
            bus_rdata <= bus_rd ? next_rdata : '0;
        end
    end

    // ==========================================================
    // checks
    // all properties run on the system clock and stand down in reset, so
    // the first edges after release never see unset state
    a_imm_duty_update: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (upd_now && !mode[`PCU_MODE_CPD]) |=> (duty == $past(bus_wdata[`PCU_CW-1:0])))
        else $error("immediate duty update missed");

    a_zero_period_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (upd_commit && upd_tgt_period && period == `PCU_CNT_ZERO && !upd_now)
        |=> (period == `PCU_CNT_ZERO))
        else $error("period update applied with zero period");

    a_first_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_enable && !running) |=> (running && cnt == `PCU_CNT_ZERO))
        else $error("first period not started from zero");

    a_left_restart: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (running && !calg && period_end && !wr_disable && !wr_enable)
        |=> (cnt == `PCU_CNT_ONE))
        else $error("left period did not restart at one");

    a_early_disable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_disable && running && !tick_seen) |=> (en_flag && !running && !pwm_oe))
        else $error("early disable status wrong");

    a_buffered_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_update && !upd_now && !upd_commit && !mode[`PCU_MODE_CPD] && !wr_duty)
        |=> (duty == $past(duty)))
        else $error("buffered duty changed before period end");

    a_buffer_commit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (upd_commit && !upd_tgt_period && !wr_update && !wr_duty)
        |=> (duty == $past(upd_val) && !upd_pending))
        else $error("buffered duty not applied at period end");

    a_imm_period_update: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (upd_now && mode[`PCU_MODE_CPD]) |=> (period == $past(bus_wdata[`PCU_CW-1:0])))
        else $error("immediate period update missed");

    a_late_disable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wr_disable && running && tick_seen) |=> (!en_flag && !running && !pwm_oe))
        else $error("normal disable status wrong");

    a_enable_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_enable |=> (en_flag && running && !tick_seen))
        else $error("enable did not start the channel");

    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !bus_rd |=> (bus_rdata == '0))
        else $error("read data outside read cycle");
endmodule : pcu_channel

// ---- design/pcu_cfg.svh ----
// constants for the per-channel pulse-width modulation block
//
// Notes on behaviour
// - counter at 0 or 1: update applies at once
// - period zero: buffered period update is skipped
// - left mode: first period from 0, then 1
// - early disable stops output, flag stays set
`ifndef PCU_CFG_SVH
`define PCU_CFG_SVH
// ==========================================================
// widths
`define PCU_CW          16
`define PCU_AW          6
`define PCU_EVW         2
`define PCU_PREW        4
`define PCU_DIVW        16
// ==========================================================
// register offsets (byte addresses)
`define PCU_OFS_ENABLE  6'h00
`define PCU_OFS_DISABLE 6'h04
`define PCU_OFS_STATUS  6'h08
`define PCU_OFS_MODE    6'h0c
`define PCU_OFS_DUTY    6'h10
`define PCU_OFS_PERIOD  6'h14
`define PCU_OFS_UPDATE  6'h18
`define PCU_OFS_COUNT   6'h1c
`define PCU_OFS_ISR     6'h20
`define PCU_OFS_IMR     6'h24
// ==========================================================
// mode register fields
`define PCU_MODE_CPOL   0
`define PCU_MODE_CALG   1
`define PCU_MODE_CPD    2
`define PCU_MODE_PRE_LO 4
`define PCU_MODE_PRE_HI 7
`define PCU_CMD_BIT     0
// ==========================================================
// event bits and reset values
`define PCU_EV_PERIOD   0
`define PCU_EV_UPDATE   1
`define PCU_CNT_ZERO    16'h0000
`define PCU_CNT_ONE     16'h0001
`define PCU_DUTY_RST    16'h0008
`define PCU_PERIOD_RST  16'h0010
`define PCU_MODE_RST    8'h00
`endif

// ---- design/pcu_pkg.sv ----
// types shared by the modulation block modules
`include "pcu_cfg.svh"
package pcu_pkg;
    typedef logic [`PCU_CW-1:0]  pcu_cnt_t;    // counter, duty and period width
    typedef logic [`PCU_AW-1:0]  pcu_addr_t;   // register byte address
    typedef logic [31:0]         pcu_word_t;   // bus data word
    typedef logic [`PCU_EVW-1:0] pcu_ev_t;     // event vector
    typedef logic [`PCU_PREW-1:0] pcu_pre_t;   // prescaler select
    // channel run state, one-hot
    typedef enum logic [1:0] {
        PCU_IDLE = 2'b01,
        PCU_RUN  = 2'b10
    } pcu_state_e;
endpackage : pcu_pkg

// ---- design/pcu_evt_if.sv ----
// event and interrupt register signals between channel core and interrupt unit
`timescale 1ns/10ps
interface pcu_evt_if;
    import pcu_pkg::*;
    pcu_ev_t  event_pulse;   // one-cycle events from the channel
    logic     clr_wr;        // write-one-to-clear strobe
    logic     mask_wr;       // mask register write strobe
    pcu_ev_t  wr_bits;       // bus write data, low bits
    pcu_ev_t  status;        // sticky status
    pcu_ev_t  mask;          // interrupt mask
    modport src  (output event_pulse, clr_wr, mask_wr, wr_bits, input status, mask);
    modport sink (input event_pulse, clr_wr, mask_wr, wr_bits, output status, mask);
endinterface : pcu_evt_if

// ---- design/pcu_clkdiv.sv ----
// selected-clock tick generator for one channel
`timescale 1ns/10ps
`include "pcu_cfg.svh"
module pcu_clkdiv #(
    parameter int DIVW = `PCU_DIVW        // divider width
) (
    input  wire logic             clk_sys,  // system clock
    input  wire logic             reset_n,  // async reset, active low
    input  wire logic             run,      // divider runs while high
    input  wire pcu_pkg::pcu_pre_t pre_sel, // divide by two to this power
    output logic                  tick      // one pulse per selected clock period
);
    import pcu_pkg::*;
    // ==========================================================
    // free divider, restarted whenever the channel stops
    logic [DIVW-1:0] div;                   // divider count
    logic [DIVW-1:0] div_mask;              // low bits that must be all ones

    assign div_mask = DIVW'((DIVW+1)'(1) << pre_sel) - DIVW'(1);
    assign tick     = run && ((div & div_mask) == div_mask);

    // divider register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div <= '0;
        end else if (!run) begin
            div <= '0;                      // phase aligned to enable
        end else begin
            div <= div + DIVW'(1);
        end
    end
endmodule : pcu_clkdiv

// ---- design/pcu_irq.sv ----
// sticky event status, mask and interrupt line
`timescale 1ns/10ps
module pcu_irq (
    input  wire logic clk_sys,  // system clock
    input  wire logic reset_n,  // async reset, active low
    pcu_evt_if.sink   ev,       // events and register strobes
    output logic      irq       // level interrupt
);
    import pcu_pkg::*;
    // ==========================================================
    // status: a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ev.status <= '0;
        end else begin
            ev.status <= (ev.status & ~(ev.clr_wr ? ev.wr_bits : '0)) | ev.event_pulse;
        end
    end

    // mask register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ev.mask <= '0;
        end else if (ev.mask_wr) begin
            ev.mask <= ev.wr_bits;
        end
    end

    assign irq = |(ev.status & ev.mask);
endmodule : pcu_irq

// ---- verification/pcu_load_model.sv ----
// load model on the modulated line: pull-up plus a low-cycle counter
`timescale 1ns/10ps
module pcu_load_model (
    input  wire logic  clk_sys,  // system clock
    input  wire logic  pwm_out,  // level driven by the channel
    input  wire logic  pwm_oe,   // high while the channel drives
    output logic       line,     // resolved pin level
    output int unsigned n_low    // cycles seen low since time zero
);
    // ==========================================================
    // pin resolution
    // released pin floats to the pull-up, so a stopped channel reads
    // a constant high level, never a stale copy of the last output
    assign line = pwm_oe ? pwm_out : 1'b1;

    // ==========================================================
    // low-time counter
    // counts only; the bench takes differences over whole periods
    always @(posedge clk_sys) begin
        if (line == 1'b0) begin
            n_low <= n_low + 1;
        end
    end
endmodule : pcu_load_model

// ---- verification/pcu_channel_tb.sv ----
// self-checking bench for the modulation channel
`timescale 1ns/10ps
`include "pcu_cfg.svh"
`define PCU_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pcu_channel_tb;
    import pcu_pkg::*;
    typedef struct { logic chk; pcu_word_t val; } pcu_exp_s;
    logic      clk_sys;     // system clock
    logic      reset_n;     // async reset, active low
    pcu_addr_t bus_addr;    // register address
    pcu_word_t bus_wdata;   // write data
    logic      bus_wr;      // write strobe
    logic      bus_rd;      // read strobe
    pcu_word_t bus_rdata;   // read data
    logic      pwm_out;     // channel output
    logic      pwm_oe;      // channel drive enable
    logic      irq;         // interrupt
    logic      line;        // resolved pin
    int unsigned n_low;     // low cycles from the load
    int        mismatches;  // failed comparisons
    int        n_checks;    // comparisons made
    pcu_exp_s  exp_q[$];    // expected read results, oldest first
    logic      rd_pend;     // read data due at this edge
    pcu_exp_s  e;           // note taken off the queue
    pcu_word_t v;           // polled value
    int        d;           // random duty
    int        n0;          // low count snapshot
    pcu_word_t u1;          // immediate update value
    pcu_word_t u2;          // buffered update value

    pcu_channel u_pcu_channel (.clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
    pcu_load_model u_pcu_load_model (.clk_sys(clk_sys), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .line(line), .n_low(n_low));

    // ==========================================================
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // read monitor: data stand only in the cycle after the strobe
    initial rd_pend = 1'b0;
    always @(posedge clk_sys) begin
        if (rd_pend) begin
            e = exp_q.pop_front();
            if (e.chk) `PCU_CHK(bus_rdata, e.val)
        end
        rd_pend = bus_rd;
    end

    // ==========================================================
    // bus tasks; strobes stay up until the next task or cyc lowers them
    task automatic wr(input pcu_addr_t a, input pcu_word_t dt);
        bus_addr  <= a;
        bus_wdata <= dt;
        bus_wr    <= 1'b1;
        bus_rd    <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input pcu_addr_t a, input pcu_word_t ev, input logic c);
        exp_q.push_back('{c, ev});
        bus_addr <= a;
        bus_rd   <= 1'b1;
        bus_wr   <= 1'b0;
        @(posedge clk_sys);
    endtask : rd
    task automatic cyc(input int n);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    // unchecked read whose value the sequence itself needs
    task automatic peek(input pcu_addr_t a, output pcu_word_t r);
        rd(a, '0, 1'b0);
        bus_rd <= 1'b0;
        #1 r = bus_rdata;
        @(posedge clk_sys);
    endtask : peek
    // wait until the counter has just moved onto the target value
    task automatic poll_cnt(input pcu_word_t t);
        pcu_word_t prev;
        prev = 32'hffff_ffff;
        for (int i = 0; i < 300; i++) begin
            peek(`PCU_OFS_COUNT, v);
            if (v == t && prev != t) return;
            prev = v;
        end
        mismatches++;
        give_verdict();
    endtask : poll_cnt
    // wait until a buffered update has landed
    task automatic wait_upd();
        v = '0;
        for (int i = 0; i < 300 && !v[`PCU_EV_UPDATE]; i++) peek(`PCU_OFS_ISR, v);
        if (!v[`PCU_EV_UPDATE]) begin
            mismatches++;
            give_verdict();
        end
    endtask : wait_upd

    // ==========================================================
    // closing report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // main sequence
    initial begin
        reset_n = 1'b0; bus_addr = '0; bus_wdata = '0; bus_wr = 1'b0; bus_rd = 1'b0;
        mismatches = 0; n_checks = 0;
        void'($urandom(45));
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        // reset values, unmapped address reads zero
        rd(`PCU_OFS_MODE, 32'h0000_0000, 1'b1);
        rd(`PCU_OFS_DUTY, 32'h0000_0008, 1'b1);
        rd(`PCU_OFS_PERIOD, 32'h0000_0010, 1'b1);
        rd(`PCU_OFS_COUNT, 32'h0000_0000, 1'b1);
        rd(`PCU_OFS_STATUS, 32'h0000_0000, 1'b1);
        rd(`PCU_OFS_ISR, 32'h0000_0000, 1'b1);
        rd(`PCU_OFS_IMR, 32'h0000_0000, 1'b1);
        rd(6'h3c, 32'h0000_0000, 1'b1);
        cyc(2);
        #1 `PCU_CHK({pwm_out, pwm_oe, irq}, 3'b100)
        $display("test reset done");

        // left mode counter: first period from zero, later from one
        wr(`PCU_OFS_PERIOD, 32'h0000_0002);
        wr(`PCU_OFS_MODE, 32'h0000_0000);
        wr(`PCU_OFS_ENABLE, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            rd(`PCU_OFS_COUNT, (i == 0) ? 0 : ((i % 2) ? 1 : 2), 1'b1);
        end
        cyc(2);
        #1 `PCU_CHK(pwm_oe, 1'b1)
        wr(`PCU_OFS_DISABLE, 32'h0000_0001);
        rd(`PCU_OFS_STATUS, 32'h0000_0000, 1'b1);
        cyc(2);
        $display("test counter start done");

        // duty against low time: left runs 1..8, low for duty-1 cycles;
        // center runs 1..8..0 in 16 cycles, high polarity, low 17-2*duty
        d = 1 + ($urandom % 7);
        wr(`PCU_OFS_PERIOD, 32'h0000_0008);
        wr(`PCU_OFS_DUTY, d);
        for (int m = 0; m < 2; m++) begin
            wr(`PCU_OFS_MODE, m ? 32'h0000_0003 : 32'h0000_0000);
            wr(`PCU_OFS_ENABLE, 32'h0000_0001);
            cyc(20);
            n0 = n_low;
            cyc(32);
            `PCU_CHK(n_low - n0, m ? 34 - 4 * d : 4 * (d - 1))
            wr(`PCU_OFS_DISABLE, 32'h0000_0001);
            cyc(2);
        end
        $display("test duty done");

        // update path with the slow clock, divide by 8
        wr(`PCU_OFS_DUTY, 32'h0000_0004);
        wr(`PCU_OFS_MODE, 32'h0000_0030);
        wr(`PCU_OFS_ENABLE, 32'h0000_0001);
        u1 = 1 + ($urandom % 8);
        u2 = 1 + ($urandom % 8);
        poll_cnt(1);
        wr(`PCU_OFS_UPDATE, u1);
        rd(`PCU_OFS_DUTY, u1, 1'b1);
        poll_cnt(4);
        wr(`PCU_OFS_ISR, 32'h0000_0003);
        wr(`PCU_OFS_UPDATE, u2);
        rd(`PCU_OFS_DUTY, u1, 1'b1);
        rd(`PCU_OFS_UPDATE, u2, 1'b1);
        wait_upd();
        rd(`PCU_OFS_DUTY, u2, 1'b1);
        // buffered period update, then an immediate one while idle
        wr(`PCU_OFS_MODE, 32'h0000_0034);
        poll_cnt(4);
        wr(`PCU_OFS_ISR, 32'h0000_0003);
        wr(`PCU_OFS_UPDATE, 32'h0000_0006);
        rd(`PCU_OFS_PERIOD, 32'h0000_0008, 1'b1);
        wait_upd();
        rd(`PCU_OFS_PERIOD, 32'h0000_0006, 1'b1);
        wr(`PCU_OFS_DISABLE, 32'h0000_0001);
        rd(`PCU_OFS_STATUS, 32'h0000_0000, 1'b1);
        cyc(2);
        wr(`PCU_OFS_UPDATE, 32'h0000_0008);
        rd(`PCU_OFS_PERIOD, 32'h0000_0008, 1'b1);
        $display("test update done");

        // disable before the first selected-clock tick
        wr(`PCU_OFS_ENABLE, 32'h0000_0001);
        wr(`PCU_OFS_DISABLE, 32'h0000_0001);
        cyc(3);
        #1 `PCU_CHK(pwm_oe, 1'b0)
        rd(`PCU_OFS_STATUS, 32'h0000_0001, 1'b1);
        cyc(2);
        $display("test early disable done");

        // interrupt: raise, mask, clear
        wr(`PCU_OFS_MODE, 32'h0000_0000);
        wr(`PCU_OFS_ENABLE, 32'h0000_0001);
        wr(`PCU_OFS_ISR, 32'h0000_0003);
        cyc(10);
        wr(`PCU_OFS_DISABLE, 32'h0000_0001);
        rd(`PCU_OFS_ISR, 32'h0000_0001, 1'b1);
        cyc(2);
        #1 `PCU_CHK(irq, 1'b0)
        wr(`PCU_OFS_IMR, 32'h0000_0001);
        rd(`PCU_OFS_IMR, 32'h0000_0001, 1'b1);
        cyc(1);
        #1 `PCU_CHK(irq, 1'b1)
        wr(`PCU_OFS_ISR, 32'h0000_0001);
        rd(`PCU_OFS_ISR, 32'h0000_0000, 1'b1);
        cyc(2);
        #1 `PCU_CHK(irq, 1'b0)
        $display("test interrupt done");
        give_verdict();
    end
endmodule : pcu_channel_tb
